// File: rtl/pcdc_params.svh
`ifndef PCDC_PARAMS_SVH
`define PCDC_PARAMS_SVH
`define PCDC_OFS_CAP_HDR 8'hC0
`define PCDC_OFS_DEV_CAPS 8'hC4
`define PCDC_CAP_ID 8'h10
`define PCDC_NEXT_PTR 8'h00
`define PCDC_CAP_VER 4'h2
`define PCDC_TYPE_UP 4'h5
`define PCDC_TYPE_DN 4'h6
`define PCDC_PL_128 3'h0
`define PCDC_PL_256 3'h1
`define PCDC_PL_512 3'h2
`define PCDC_RBE_RST 1'h1
`define PCDC_SLOT_RST_DN 1'h1
`define PCDC_SLOT_RST_UP 1'h0
`endif

// File: rtl/pcdc_pkg.sv
`default_nettype none
package pcdc_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] offset;
  } pcdc_cfg_rd_s;
  typedef struct packed {
    logic valid;
    logic [1:0] scale;
    logic [7:0] value;
  } pcdc_spl_msg_s;
  typedef struct packed {
    logic slot_present;
    logic [2:0] payload;
    logic role_err;
  } pcdc_ovr_s;
  typedef struct packed {
    logic init_done;
    logic slot_present;
    logic [2:0] payload;
    logic role_err;
    logic [7:0] pwr_value;
    logic [1:0] pwr_scale;
    logic rd_valid;
    logic [31:0] rd_data;
  } pcdc_state_s;
endpackage
`default_nettype wire

// File: rtl/pcdc_regs.sv
`include "pcdc_params.svh"
`default_nettype none
// Summary of operation
// - capability header low byte reads 10h.
// - next-capability pointer reads 00h, ending the list.
// - capability version field reads 2h.
// - port type reads 0101b upstream, 0110b downstream.
// - slot-present resets 0 upstream, 1 downstream.
// - slot, payload and role-error defaults replaceable by sideband or EEPROM.
// - interrupt message number always reads zero.
// - payload codes 000b 128, 001b 256, 010b 512 bytes; others reserved.
// - payload resets 001b with strap low, 010b with strap high.
// - either port reports 512-byte maximum payload only with strap high or an override to 010b.
// - phantom-function field reads 00b.
// - extended tag support bit reads 0.
// - L0s and L1 acceptable latency fields read 000b.
// - role-based error support bit resets to 1.
// - upstream captures slot power value from message, else 00h.
// - upstream captures power scale from message, else 00b.
module pcdc_regs
  import pcdc_pkg::*;
#(
  parameter bit UPSTREAM = 1'b1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic payload_large_strap,
  input wire pcdc_cfg_rd_s cfg_rd,
  input wire pcdc_spl_msg_s spl_msg,
  input wire logic ovr_we,
  input wire pcdc_ovr_s ovr,
  output logic rd_valid,
  output logic [31:0] rd_data
);

  pcdc_state_s st_q;
  pcdc_state_s st_d;

  function automatic logic payload_ok(input logic [2:0] code);
    payload_ok = (code == `PCDC_PL_128) || (code == `PCDC_PL_256) || (code == `PCDC_PL_512);
  endfunction

  function automatic logic [31:0] hdr_word(input logic slot);
    hdr_word = '0;
    hdr_word[7:0] = `PCDC_CAP_ID;
    hdr_word[15:8] = `PCDC_NEXT_PTR;
    hdr_word[19:16] = `PCDC_CAP_VER;
    hdr_word[23:20] = UPSTREAM ? `PCDC_TYPE_UP : `PCDC_TYPE_DN;
    hdr_word[24] = slot;
    hdr_word[29:25] = 5'h00;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.rd_valid = 1'b0;
    if (!st_q.init_done) begin
      // strap caught on first clock after reset release
      st_d.init_done = 1'b1;
      st_d.payload = payload_large_strap ? `PCDC_PL_512 : `PCDC_PL_256;
    end
    if (ovr_we) begin
      st_d.slot_present = ovr.slot_present;
      st_d.role_err = ovr.role_err;
      if (payload_ok(ovr.payload)) begin
        st_d.payload = ovr.payload;
      end
    end
    if (UPSTREAM && spl_msg.valid) begin
      st_d.pwr_value = spl_msg.value;
      st_d.pwr_scale = spl_msg.scale;
    end
    if (cfg_rd.valid) begin
      st_d.rd_valid = 1'b1;
      case (cfg_rd.offset)
        `PCDC_OFS_CAP_HDR: begin
          st_d.rd_data = hdr_word(st_q.slot_present);
        end
        `PCDC_OFS_DEV_CAPS: begin
          st_d.rd_data = '0;
          st_d.rd_data[2:0] = st_q.payload;
          st_d.rd_data[4:3] = 2'h0;
          st_d.rd_data[5] = 1'b0;
          st_d.rd_data[11:6] = 6'h00;
          st_d.rd_data[15] = st_q.role_err;
          st_d.rd_data[25:18] = st_q.pwr_value;
          st_d.rd_data[27:26] = st_q.pwr_scale;
        end
        default: begin
          st_d.rd_data = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.slot_present <= UPSTREAM ? `PCDC_SLOT_RST_UP : `PCDC_SLOT_RST_DN;
      st_q.payload <= payload_large_strap ? `PCDC_PL_512 : `PCDC_PL_256;
      st_q.role_err <= `PCDC_RBE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_valid = st_q.rd_valid;
  assign rd_data = st_q.rd_data;

  //////////////////////////////////////////////////////////////////////////////
  property p_hdr_id;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC0 |=> rd_valid && rd_data[15:0] == 16'h0010;
  endproperty
  a_hdr_id: assert property (p_hdr_id) else $error("header id or pointer wrong");
  property p_hdr_ver;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC0 |=> rd_data[19:16] == 4'h2 && rd_data[31:25] == 7'h00;
  endproperty
  a_hdr_ver: assert property (p_hdr_ver) else $error("version or msg number wrong");
  property p_type;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC0 |=> rd_data[23:20] == (UPSTREAM ? 4'h5 : 4'h6);
  endproperty
  a_type: assert property (p_type) else $error("port type wrong");
  property p_slot_rst;
    @(posedge mclk) $fell(sys_rst) |-> st_q.slot_present == !UPSTREAM && st_q.role_err;
  endproperty
  a_slot_rst: assert property (p_slot_rst) else $error("slot or role reset wrong");
  property p_strap;
    @(posedge mclk) disable iff (sys_rst)
    !st_q.init_done && !ovr_we |=> st_q.payload == ($past(payload_large_strap) ? 3'h2 : 3'h1);
  endproperty
  a_strap: assert property (p_strap) else $error("strap payload wrong");
  property p_caps_fixed;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC4 |=> rd_data[14:3] == 12'h000 && rd_data[31:28] == 4'h0;
  endproperty
  a_caps_fixed: assert property (p_caps_fixed) else $error("fixed caps bits nonzero");
  property p_ovr;
    @(posedge mclk) disable iff (sys_rst)
    ovr_we |=> st_q.slot_present == $past(ovr.slot_present) && st_q.role_err == $past(ovr.role_err);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override not applied");
  property p_pl_legal;
    @(posedge mclk) disable iff (sys_rst)
    st_q.init_done |-> payload_ok(st_q.payload);
  endproperty
  a_pl_legal: assert property (p_pl_legal) else $error("reserved payload code");
  property p_spl;
    @(posedge mclk) disable iff (sys_rst)
    spl_msg.valid ##1 (cfg_rd.valid && cfg_rd.offset == 8'hC4 && !spl_msg.valid)
      |=> rd_data[27:18] == (UPSTREAM ? {$past(spl_msg.scale, 2), $past(spl_msg.value, 2)} : 10'h000);
  endproperty
  a_spl: assert property (p_spl) else $error("slot power capture wrong");
  property p_unmapped;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset != 8'hC0 && cfg_rd.offset != 8'hC4 |=> rd_data == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

  //////////////////////////////////////////////////////////////////////////////
  // read answer framing
  property p_rd_follow;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid
      |=> rd_valid;
  endproperty
  a_rd_follow: assert property (p_rd_follow) else $error("read answer missing");
  property p_rd_quiet;
    @(posedge mclk) disable iff (sys_rst)
    !cfg_rd.valid
      |=> !rd_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray read answer");
  property p_rd_hold;
    @(posedge mclk) disable iff (sys_rst)
    !cfg_rd.valid
      |=> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_rst_out;
    @(posedge mclk)
    sys_rst
      |=> !rd_valid && rd_data == 32'h0000_0000;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("read output not cleared by reset");

  //////////////////////////////////////////////////////////////////////////////
  // header fields
  property p_hdr_slot;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC0
      |=> rd_data[24] == $past(st_q.slot_present);
  endproperty
  a_hdr_slot: assert property (p_hdr_slot) else $error("slot bit not as stored");
  property p_hdr_msgnum;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC0
      |=> rd_data[29:25] == 5'h00;
  endproperty
  a_hdr_msgnum: assert property (p_hdr_msgnum) else $error("message number nonzero");
  property p_hdr_rsvd;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC0
      |=> rd_data[31:30] == 2'h0;
  endproperty
  a_hdr_rsvd: assert property (p_hdr_rsvd) else $error("header reserved bits nonzero");

  //////////////////////////////////////////////////////////////////////////////
  // capability fields
  property p_caps_pl;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC4
      |=> rd_data[2:0] == $past(st_q.payload);
  endproperty
  a_caps_pl: assert property (p_caps_pl) else $error("payload field not as stored");
  property p_caps_role;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC4
      |=> rd_data[15] == $past(st_q.role_err);
  endproperty
  a_caps_role: assert property (p_caps_role) else $error("role error bit not as stored");
  property p_caps_rsvd;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC4
      |=> rd_data[17:16] == 2'h0 && rd_data[14:12] == 3'h0;
  endproperty
  a_caps_rsvd: assert property (p_caps_rsvd) else $error("caps reserved bits nonzero");
  property p_caps_lat;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC4
      |=> rd_data[11:6] == 6'h00;
  endproperty
  a_caps_lat: assert property (p_caps_lat) else $error("latency fields nonzero");
  property p_caps_req;
    @(posedge mclk) disable iff (sys_rst)
    cfg_rd.valid && cfg_rd.offset == 8'hC4
      |=> rd_data[5:3] == 3'h0;
  endproperty
  a_caps_req: assert property (p_caps_req) else $error("requester fields nonzero");
  property p_dn_pwr_rd;
    @(posedge mclk) disable iff (sys_rst)
    !UPSTREAM && cfg_rd.valid && cfg_rd.offset == 8'hC4
      |=> rd_data[27:18] == 10'h000;
  endproperty
  a_dn_pwr_rd: assert property (p_dn_pwr_rd) else $error("downstream slot power nonzero");

  //////////////////////////////////////////////////////////////////////////////
  // stored state
  property p_dn_pwr_st;
    @(posedge mclk) disable iff (sys_rst)
    !UPSTREAM
      |-> st_q.pwr_value == 8'h00 && st_q.pwr_scale == 2'h0;
  endproperty
  a_dn_pwr_st: assert property (p_dn_pwr_st) else $error("downstream power state nonzero");
  property p_pwr_load;
    @(posedge mclk) disable iff (sys_rst)
    UPSTREAM && spl_msg.valid
      |=> st_q.pwr_value == $past(spl_msg.value) && st_q.pwr_scale == $past(spl_msg.scale);
  endproperty
  a_pwr_load: assert property (p_pwr_load) else $error("slot power not loaded");
  property p_pwr_keep;
    @(posedge mclk) disable iff (sys_rst)
    !spl_msg.valid
      |=> $stable(st_q.pwr_value) && $stable(st_q.pwr_scale);
  endproperty
  a_pwr_keep: assert property (p_pwr_keep) else $error("slot power moved without message");
  property p_ovr_pl;
    @(posedge mclk) disable iff (sys_rst)
    ovr_we && payload_ok(ovr.payload)
      |=> st_q.payload == $past(ovr.payload);
  endproperty
  a_ovr_pl: assert property (p_ovr_pl) else $error("payload override not applied");
  property p_ovr_bad;
    @(posedge mclk) disable iff (sys_rst)
    ovr_we && !payload_ok(ovr.payload) && st_q.init_done
      |=> $stable(st_q.payload);
  endproperty
  a_ovr_bad: assert property (p_ovr_bad) else $error("reserved payload code taken");
  property p_cfg_keep;
    @(posedge mclk) disable iff (sys_rst)
    !ovr_we
      |=> $stable(st_q.slot_present) && $stable(st_q.role_err);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("slot or role moved without override");
  property p_pl_keep;
    @(posedge mclk) disable iff (sys_rst)
    st_q.init_done && !ovr_we
      |=> $stable(st_q.payload);
  endproperty
  a_pl_keep: assert property (p_pl_keep) else $error("payload moved without override");
  property p_rst_pl;
    @(posedge mclk)
    $fell(sys_rst)
      |-> st_q.payload == ($past(payload_large_strap) ? 3'h2 : 3'h1);
  endproperty
  a_rst_pl: assert property (p_rst_pl) else $error("payload reset value wrong");
  property p_rst_pwr;
    @(posedge mclk)
    $fell(sys_rst)
      |-> st_q.pwr_value == 8'h00 && st_q.pwr_scale == 2'h0;
  endproperty
  a_rst_pwr: assert property (p_rst_pwr) else $error("slot power reset value wrong");
  c_rd_hdr: cover property (@(posedge mclk) cfg_rd.valid && cfg_rd.offset == 8'hC0);
  c_rd_caps: cover property (@(posedge mclk) cfg_rd.valid && cfg_rd.offset == 8'hC4);
  c_spl: cover property (@(posedge mclk) spl_msg.valid);
  c_ovr: cover property (@(posedge mclk) ovr_we);
  c_strap_low: cover property (@(posedge mclk) $fell(sys_rst) && !payload_large_strap);

endmodule
`default_nettype wire

// File: sim/pcdc_host.sv
`default_nettype none
module pcdc_host
  import pcdc_pkg::*;
(
  input wire logic go,
  input wire logic [7:0] ofs,
  output var pcdc_cfg_rd_s cfg_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  // read request lasts exactly the cycle that go is high, offset held with it
  assign cfg_rd = '{valid: go, offset: ofs};
endmodule
`default_nettype wire

// File: sim/testbench.sv
`default_nettype none
module testbench;
  import pcdc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic go = 1'b0;
  logic strap = 1'b1;
  logic [7:0] ofs = 8'h00;
  logic ovr_we = 1'b0;
  pcdc_ovr_s ovr = '0;
  pcdc_spl_msg_s spl = '0;
  pcdc_cfg_rd_s cfg_rd;
  logic [1:0] rv;
  logic [31:0] rd [2];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  always #10 mclk = ~mclk;
  pcdc_host u_host(.go(go), .ofs(ofs), .cfg_rd(cfg_rd));
  ////////////////////////////////////////////////////////////////
  // instance 0 is the upstream port, instance 1 a downstream port
  for (genvar i = 0; i < 2; i++) begin : g_dut
    pcdc_regs #(.UPSTREAM(i == 0)) DUT(.mclk(mclk), .sys_rst(sys_rst), .payload_large_strap(strap),
      .cfg_rd(cfg_rd), .spl_msg(spl), .ovr_we(ovr_we), .ovr(ovr), .rd_valid(rv[i]), .rd_data(rd[i]));
  end
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // answer is checked in the one cycle rd_valid stands
  task automatic rd2(input logic [7:0] o, input logic [31:0] e_up, input logic [31:0] e_dn);
    @(posedge mclk);
    go <= 1'b1;
    ofs <= o;
    spl.valid <= 1'b0;
    @(posedge mclk);
    go <= 1'b0;
    #1;
    cmp({30'h0, rv}, 32'h3);
    cmp(rd[0], e_up);
    cmp(rd[1], e_dn);
    @(posedge mclk);
    #1;
    cmp({30'h0, rv}, 32'h0);
  endtask
  task automatic set_ovr(input logic s, input logic [2:0] p, input logic r);
    @(posedge mclk);
    ovr_we <= 1'b1;
    ovr <= '{slot_present: s, payload: p, role_err: r};
    @(posedge mclk);
    ovr_we <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd2(8'hC0, 32'h0052_0010, 32'h0162_0010);
    rd2(8'hC4, 32'h0000_8002, 32'h0000_8002);
  endtask
  task automatic t_power();
    @(posedge mclk);
    spl <= '{valid: 1'b1, scale: 2'h3, value: 8'hA5};
    rd2(8'hC4, 32'h0E94_8002, 32'h0000_8002);
  endtask
  task automatic t_override();
    set_ovr(1'b1, 3'h0, 1'b0);
    rd2(8'hC0, 32'h0152_0010, 32'h0162_0010);
    rd2(8'hC4, 32'h0E94_0000, 32'h0000_0000);
    set_ovr(1'b0, 3'h7, 1'b1);
    rd2(8'hC0, 32'h0052_0010, 32'h0062_0010);
    rd2(8'hC4, 32'h0E94_8000, 32'h0000_8000);
    set_ovr(1'b1, 3'h1, 1'b1);
    rd2(8'hC4, 32'h0E94_8001, 32'h0000_8001);
  endtask
  task automatic t_unmapped();
    rd2(8'hC8, 32'h0000_0000, 32'h0000_0000);
  endtask
  // second reset with the strap low restores every default
  task automatic t_strap_low();
    @(posedge mclk);
    sys_rst <= 1'b1;
    strap <= 1'b0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rd2(8'hC4, 32'h0000_8001, 32'h0000_8001);
    rd2(8'hC0, 32'h0052_0010, 32'h0162_0010);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_power();
    t_override();
    t_unmapped();
    t_strap_low();
    stop_test();
  end
endmodule
`default_nettype wire
